// ---- src/scm_params.svh ----
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH
// What this block does
// (R01) every power-up starts in command mode and needs a fresh configuration load
// (R02) user i/o stays released, high impedance, through power-up and configuration
// (R03) after loading, initialization resets user registers, enables i/o, then starts logic; the code enables i/o in the same cycle user mode starts
// (R04) configuration plus initialization is command mode; user mode only after initialization
// (R05) reconfig pin forces command mode; new data loads, reinitializes, user mode resumes
// (R06) whole reconfiguration cycle finishes in under 100 ms
// (R07) data arrives by configuration memory, passive serial, or passive serial async scheme
// (R08) chained devices link enable-out of one to enable-in of the next
// (R09) the memory or controller may start configuration at power-up unaided
// (R10) enable-out stays inactive until this device's own load completes
// ============================================================
// configuration image and timing
`define SCM_CFG_BITS 16'h0100
`define SCM_INIT_CYCLES 8'h10
`define SCM_RECFG_LIMIT_MS 100
`define SCM_CLK_MHZ 125
`define SCM_RECFG_LIMIT_CYC (`SCM_RECFG_LIMIT_MS * 1000 * `SCM_CLK_MHZ)
`define SCM_IO_WIDTH 8
`endif

// ---- src/scm_pkg.sv ----
package scm_pkg;
  // scheme select encodings
  typedef enum logic [1:0] {
    SCM_SCHEME_MEMORY,
    SCM_SCHEME_PASSIVE,
    SCM_SCHEME_PASSIVE_ASYNC,
    SCM_SCHEME_RSVD
  } scm_scheme_t;
endpackage : scm_pkg

// ---- src/scm_config_ctrl.sv ----
`timescale 1ns/100ps
`include "scm_params.svh"
module scm_config_ctrl #(
  parameter logic [27:0] RECFG_LIMIT = 28'(`SCM_RECFG_LIMIT_CYC)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic config_enable_in_n,
  input wire logic in_circuit_reconfig_n,
  input wire logic [1:0] scheme_sel,
  input wire logic cfg_clk,
  input wire logic cfg_data,
  input wire logic cfg_data_valid,
  output logic cfg_data_ready,
  output logic config_enable_out_n,
  output logic user_mode,
  output logic user_reset_b,
  output logic io_oe_b,
  output logic [7:0] cfg_word,
  output logic cfg_word_valid,
  input wire logic cfg_word_ready,
  output logic config_done,
  output logic recfg_timeout
);

  // ============================================================
  // input synchronisers
  logic [1:0] ce_s, recfg_s, cclk_s, cdat_s, cval_s;
  logic [1:0] sch_s0, sch_s1;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ce_s <= 2'h3;
      recfg_s <= 2'h3;
      cclk_s <= 2'h0;
      cdat_s <= 2'h0;
      cval_s <= 2'h0;
      sch_s0 <= 2'h0;
      sch_s1 <= 2'h0;
    end else begin
      ce_s <= {ce_s[0], config_enable_in_n};
      recfg_s <= {recfg_s[0], in_circuit_reconfig_n};
      cclk_s <= {cclk_s[0], cfg_clk};
      cdat_s <= {cdat_s[0], cfg_data};
      cval_s <= {cval_s[0], cfg_data_valid};
      sch_s0 <= scheme_sel;
      sch_s1 <= sch_s0;
    end
  end
  logic cclk_d;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cclk_d <= 1'h0;
    end else begin
      cclk_d <= cclk_s[1];
    end
  end

  // ============================================================
  // bit strobe per scheme: clocked schemes use the rising edge, async uses valid
  logic bit_stb;
  always_comb begin
    case (scm_pkg::scm_scheme_t'(sch_s1))
      scm_pkg::SCM_SCHEME_MEMORY: bit_stb = cclk_s[1] & ~cclk_d; // [R07]
      scm_pkg::SCM_SCHEME_PASSIVE: bit_stb = cclk_s[1] & ~cclk_d; // [R07]
      scm_pkg::SCM_SCHEME_PASSIVE_ASYNC: bit_stb = cval_s[1]; // [R07]
      default: bit_stb = 1'h0;
    endcase
  end

  // ============================================================
  // mode machine
  typedef enum logic [2:0] {SCM_ST_WAIT, SCM_ST_LOAD, SCM_ST_INIT, SCM_ST_USER} scm_state_t;
  scm_state_t state, next_state;
  logic [15:0] bit_cnt;
  logic [7:0] init_cnt;
  logic [2:0] sh_cnt;
  logic [7:0] sh;
  logic buf_full;
  logic take;
  logic recfg_req;
  assign recfg_req = ~recfg_s[1];
  // a byte-completing bit is only taken while the buffer has room, so a stalled receiver loses nothing
  assign take = (state == SCM_ST_LOAD) & bit_stb & ~(buf_full & sh_cnt == 3'h7);

  always_comb begin
    next_state = state;
    case (state)
      SCM_ST_WAIT: if (!ce_s[1] && !recfg_req) next_state = SCM_ST_LOAD; // [R08] [R09]
      SCM_ST_LOAD: if (take && bit_cnt == `SCM_CFG_BITS - 16'h1) next_state = SCM_ST_INIT; // [R03]
      SCM_ST_INIT: if (init_cnt == `SCM_INIT_CYCLES - 8'h1) next_state = SCM_ST_USER; // [R04]
      SCM_ST_USER: next_state = SCM_ST_USER;
      default: next_state = SCM_ST_WAIT;
    endcase
    if (recfg_req) next_state = SCM_ST_WAIT; // [R05]
  end

  // power-up always lands in command mode with nothing loaded
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SCM_ST_WAIT; // [R01]
    end else begin
      state <= next_state;
    end
  end

  // bit and init counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 16'h0;
      init_cnt <= 8'h0;
    end else begin
      bit_cnt <= (state != SCM_ST_LOAD) ? 16'h0 : (take ? bit_cnt + 16'h1 : bit_cnt);
      init_cnt <= (state == SCM_ST_INIT) ? init_cnt + 8'h1 : 8'h0;
    end
  end

  // ============================================================
  // deserialiser into a two-entry buffer
  logic [7:0] buf_d [2];
  logic [1:0] buf_n;
  logic wr_ptr, rd_ptr;
  logic push, pop;
  assign buf_full = (buf_n == 2'h2);
  assign push = take & (sh_cnt == 3'h7);
  assign pop = cfg_word_valid & cfg_word_ready;
  logic [7:0] sh_next;
  assign sh_next = {sh[6:0], cdat_s[1]}; // byte as it stands once the current bit is in
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh <= 8'h0;
      sh_cnt <= 3'h0;
    end else if (state != SCM_ST_LOAD) begin
      sh_cnt <= 3'h0;
    end else if (take) begin
      sh <= {sh[6:0], cdat_s[1]};
      sh_cnt <= sh_cnt + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_d[0] <= 8'h0;
      buf_d[1] <= 8'h0;
      buf_n <= 2'h0;
      wr_ptr <= 1'h0;
      rd_ptr <= 1'h0;
    end else begin
      if (push) begin
        buf_d[wr_ptr] <= sh_next;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) rd_ptr <= ~rd_ptr;
      buf_n <= buf_n + {1'h0, push} - {1'h0, pop};
    end
  end
  // registered view of the buffer head
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_word <= 8'h0;
      cfg_word_valid <= 1'h0;
      cfg_data_ready <= 1'h0;
    end else begin
      // a byte pushed this cycle into the slot that becomes the head is not in the array yet,
      // so it is taken straight from the shifter rather than showing a stale word
      if (push && (wr_ptr == (rd_ptr ^ pop))) cfg_word <= sh_next;
      else cfg_word <= buf_d[rd_ptr ^ pop];
      cfg_word_valid <= (buf_n + {1'h0, push} - {1'h0, pop}) != 2'h0;
      cfg_data_ready <= (next_state == SCM_ST_LOAD) & (buf_n < 2'h2);
    end
  end

  // ============================================================
  // mode outputs: i/o released until user mode, registers held in init
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_oe_b <= 1'h1;
      user_mode <= 1'h0;
      user_reset_b <= 1'h0;
      config_done <= 1'h0;
      config_enable_out_n <= 1'h1;
    end else begin
      io_oe_b <= (next_state != SCM_ST_USER); // [R02] [R03]
      user_mode <= (next_state == SCM_ST_USER); // [R04]
      user_reset_b <= (next_state == SCM_ST_USER); // [R03]
      config_done <= (next_state == SCM_ST_INIT) | (next_state == SCM_ST_USER);
      config_enable_out_n <= ~((next_state == SCM_ST_INIT) | (next_state == SCM_ST_USER)); // [R10] [R08]
    end
  end

  // ============================================================
  // reconfiguration watchdog: counts from forced command mode to user mode
  logic [27:0] rc_cnt;
  logic rc_run;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_cnt <= 28'h0;
      rc_run <= 1'h0;
      recfg_timeout <= 1'h0;
    end else begin
      if (recfg_req) begin
        rc_run <= 1'h1;
        rc_cnt <= 28'h0;
        recfg_timeout <= 1'h0;
      end else if (rc_run) begin
        if (state == SCM_ST_USER) rc_run <= 1'h0;
        else if (rc_cnt >= RECFG_LIMIT - 28'h1) recfg_timeout <= 1'h1; // [R06]
        else rc_cnt <= rc_cnt + 28'h1;
      end
    end
  end

  // ============================================================
  // checks
  sequence s_init_done;
    state == SCM_ST_INIT && init_cnt == `SCM_INIT_CYCLES - 8'h1;
  endsequence
  // mode outputs are registered from next_state, so they line up with state in the same cycle
  a_io_held: assert property (@(posedge clk) disable iff (!rst_b) // [R02]
    state != SCM_ST_USER |-> io_oe_b) else $error("io enabled outside user mode");
  a_user_after_init: assert property (@(posedge clk) disable iff (!rst_b) // [R04]
    (s_init_done and !recfg_req) |=> state == SCM_ST_USER ##0 io_oe_b == 1'h0)
    else $error("user mode not entered after init");
  a_init_regs: assert property (@(posedge clk) disable iff (!rst_b) // [R03]
    state == SCM_ST_INIT |-> !user_reset_b) else $error("registers released during init");
  a_recfg_force: assert property (@(posedge clk) disable iff (!rst_b) // [R05]
    recfg_req |=> state == SCM_ST_WAIT ##1 io_oe_b) else $error("reconfig did not force command mode");
  a_ceo_wait: assert property (@(posedge clk) disable iff (!rst_b) // [R10]
    (state == SCM_ST_WAIT || state == SCM_ST_LOAD) |-> config_enable_out_n)
    else $error("enable out early");
  a_ceo_chain: assert property (@(posedge clk) disable iff (!rst_b) // [R08]
    state == SCM_ST_LOAD && next_state == SCM_ST_INIT |=> !config_enable_out_n)
    else $error("enable out not passed on");
  a_load_start: assert property (@(posedge clk) disable iff (!rst_b) // [R09]
    state == SCM_ST_WAIT && !ce_s[1] && !recfg_req |=> state == SCM_ST_LOAD)
    else $error("load did not start");
  a_scheme_rsvd: assert property (@(posedge clk) disable iff (!rst_b)
    sch_s1 == 2'h3 |-> !take) else $error("bit taken under reserved scheme"); // [R07]
  a_no_overrun: assert property (@(posedge clk) disable iff (!rst_b)
    buf_full && !pop |-> !push) else $error("buffer overrun"); // [R07]
  a_timeout_flag: assert property (@(posedge clk) disable iff (!rst_b) // [R06]
    rc_run && state != SCM_ST_USER && rc_cnt == RECFG_LIMIT - 28'h1 && !recfg_req |=> recfg_timeout)
    else $error("reconfig timeout missed");
  a_powerup_load: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(user_mode) |-> $past(state) == SCM_ST_INIT) else $error("user mode without load"); // [R01]

endmodule : scm_config_ctrl

// ---- testbench/scm_cfg_source.sv ----
`timescale 1ns/100ps
// ============================================================
// serial configuration source: memory, cable or controller
module scm_cfg_source (
  input wire logic clk,
  input wire logic cfg_data_ready,
  output logic cfg_clk,
  output logic cfg_data,
  output logic cfg_data_valid
);
  initial begin
    cfg_clk = 1'b0;
    cfg_data = 1'b1;
    cfg_data_valid = 1'b0;
  end
  // msb first, one bit per strobe; waits for room so a stall loses nothing
  task automatic send_image(input logic [1:0] scheme, input logic [255:0] img, input int gap);
    for (int i = 255; i >= 0; i--) begin
      while (cfg_data_ready !== 1'b1) @(posedge clk);
      cfg_data <= img[i];
      @(posedge clk);
      if (scheme == 2'h2) cfg_data_valid <= 1'b1; // async scheme: one-cycle strobe
      else cfg_clk <= 1'b1;
      @(posedge clk);
      cfg_data_valid <= 1'b0;
      repeat (3 + gap) @(posedge clk);
      cfg_clk <= 1'b0;
      cfg_data <= ~img[i]; // no stale bit left on the line between bits
      @(posedge clk);
    end
  endtask : send_image
endmodule : scm_cfg_source

// ---- testbench/scm_config_ctrl_bench.sv ----
`timescale 1ns/100ps
`include "scm_params.svh"
module scm_config_ctrl_bench;
  localparam int LIMIT = 6000;
  logic clk, rst_b, en_in_n, recfg_n, cfg_clk, cfg_data, cfg_valid, cfg_ready;
  logic en_out_n, user_mode, user_reset_b, io_oe_b, word_valid, word_ready, done, tmo, stall;
  logic [1:0] scheme_sel;
  logic [7:0] cfg_word;
  logic [255:0] img;
  logic [7:0] got[$];
  int error_cnt, total_checks, init_cnt;
  scm_config_ctrl #(.RECFG_LIMIT(28'(LIMIT))) scm_config_ctrl_i (.clk(clk), .rst_b(rst_b),
    .config_enable_in_n(en_in_n), .in_circuit_reconfig_n(recfg_n), .scheme_sel(scheme_sel),
    .cfg_clk(cfg_clk), .cfg_data(cfg_data), .cfg_data_valid(cfg_valid), .cfg_data_ready(cfg_ready),
    .config_enable_out_n(en_out_n), .user_mode(user_mode), .user_reset_b(user_reset_b),
    .io_oe_b(io_oe_b), .cfg_word(cfg_word), .cfg_word_valid(word_valid), .cfg_word_ready(word_ready),
    .config_done(done), .recfg_timeout(tmo));
  scm_cfg_source scm_cfg_source_i (.clk(clk), .cfg_data_ready(cfg_ready), .cfg_clk(cfg_clk),
    .cfg_data(cfg_data), .cfg_data_valid(cfg_valid));
  // ============================================================
  // clock, receiver and init-phase counter
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // receiver stalls at random, or fully while the buffer is being filled
  always @(posedge clk) begin
    if (word_valid === 1'b1 && word_ready === 1'b1) got.push_back(cfg_word);
    word_ready <= !stall && ($urandom % 4 != 0);
  end
  // edges spent with load done but user mode not yet entered
  always @(posedge clk) begin
    if (done !== 1'b1) init_cnt <= 0;
    else if (user_mode !== 1'b1) init_cnt <= init_cnt + 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // ============================================================
  // one full load in scheme s, forced by the reconfig pin after the first
  task automatic load(input int s);
    int n;
    img = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    got.delete();
    scheme_sel <= 2'(s);
    if (s > 0) begin
      recfg_n <= 1'b0;
      repeat (6) @(posedge clk);
      check("user_mode forced", 0, user_mode);
      check("io_oe_b forced", 1, io_oe_b);
      recfg_n <= 1'b1;
    end
    stall <= (s == 1);
    fork
      scm_cfg_source_i.send_image(2'(s), img, $urandom % 3);
      if (s == 1) begin
        repeat (300) @(posedge clk);
        check("ready with full buffer", 0, cfg_ready);
        check("io_oe_b loading", 1, io_oe_b);
        check("user_reset_b loading", 0, user_reset_b);
        check("enable_out_n loading", 1, en_out_n);
        stall <= 1'b0;
      end
    join
    n = 0;
    while (user_mode !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("init cycles", `SCM_INIT_CYCLES, init_cnt);
    check("enable_out_n done", 0, en_out_n);
    check("io_oe_b user", 0, io_oe_b);
    check("user_reset_b user", 1, user_reset_b);
    repeat (40) @(posedge clk);
    check("byte count", 32, got.size());
    for (int k = 0; k < 32 && k < got.size(); k++) check("byte", img[255 - 8 * k -: 8], got[k]);
    check("no timeout", 0, tmo);
  endtask : load
  // watchdog sized well above three loads plus the timeout wait
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // ============================================================
  // main sequence
  initial begin
    void'($urandom(32'h5e4033c4));
    rst_b = 1'b0;
    en_in_n = 1'b1;
    recfg_n = 1'b1;
    scheme_sel = 2'h0;
    stall = 1'b0;
    word_ready = 1'b0;
    repeat (8) @(posedge clk);
    check("io_oe_b reset", 1, io_oe_b);
    check("user_mode reset", 0, user_mode);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    check("ready chain idle", 0, cfg_ready);
    check("done chain idle", 0, done);
    en_in_n <= 1'b0;
    for (int s = 0; s < 3; s++) load(s);
    // reserved scheme: a clocked image is offered but no bit may be taken, so the load starves
    scheme_sel <= 2'h3;
    recfg_n <= 1'b0;
    repeat (6) @(posedge clk);
    recfg_n <= 1'b1;
    fork
      scm_cfg_source_i.send_image(2'h3, img, 0);
      repeat (LIMIT + 100) @(posedge clk);
    join
    check("timeout flag", 1, tmo);
    check("user_mode starved", 0, user_mode);
    check("done reserved scheme", 0, done);
    check("word_valid reserved scheme", 0, word_valid);
    stop_test();
  end
endmodule : scm_config_ctrl_bench
